// [tcr_map.svh]
// Register offsets, field positions and reset values of the capture and hold block
`ifndef TCR_MAP_SVH
`define TCR_MAP_SVH

// ============================================================
// Register offsets
`define TCR_OFS_CTRL           8'h05
`define TCR_OFS_RELOAD_LO      8'h06
`define TCR_OFS_RELOAD_HI      8'h07
`define TCR_OFS_CAP16_LO       8'h08
`define TCR_OFS_CAP16_HI       8'h09
`define TCR_OFS_CAP8_LO_PHASE  8'h0A
`define TCR_OFS_CAP8_HI_PHASE  8'h0B

// ============================================================
// Control register fields
`define TCR_CTRL_RUN_BIT       0
`define TCR_CTRL_MODULO_BIT    1
`define TCR_CTRL_DONE_BIT      2

// ============================================================
// Reset values and the 8-bit count limit
`define TCR_RST_BYTE           8'h00
`define TCR_RST_WORD           16'h0000
`define TCR_CNT8_MAX           8'hFF

`endif

// [tcr_pkg.sv]
// Types shared by the capture and hold block
`default_nettype none
package tcr_pkg;

    // ============================================================
    // Sixteen-bit counter states, Gray coded
    typedef enum logic [0:0]
    {
        TCR_IDLE = 1'b0,
        TCR_RUN  = 1'b1
    } tcr_state_type;

    // ============================================================
    // Whole state of the block
    typedef struct packed
    {
        logic          sync1;
        logic          sync2;
        logic          level_prev;
        logic [7:0]    cnt8;
        logic [7:0]    cap8_hi;
        logic [7:0]    cap8_lo;
        logic [15:0]   cnt16;
        logic [15:0]   cap16;
        logic [7:0]    reload_hi;
        logic [7:0]    reload_lo;
        logic          modulo;
        logic          done;
        logic          zero_pulse;
        tcr_state_type state;
        logic [7:0]    rdata;
    } tcr_regs_type;

endpackage : tcr_pkg

`default_nettype wire

// [tcr_top.sv]
// Capture registers of the 8-bit and 16-bit counters and the 16-bit reload hold bytes
//
// Operation
// - 8-bit high-phase capture takes the count gathered while the input was one.
// - 8-bit low-phase capture takes the count gathered while the input was zero.
// - 16-bit high capture byte shows the upper byte of the captured count.
// - 16-bit low capture byte shows the lower byte of the captured count.
// - Capture registers read back captured data; writes to them change nothing.
// - Reload high byte is a read/write hold register at offset 07H.
// - At zero, modulo-N reloads high*256+low and continues; single-pass stops.
// - Hold bytes may change anytime; counter uses them only at its next load.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "tcr_map.svh"

module tcr_top
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    // Register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output var  logic [7:0] reg_rdata,
    // Measured pulse input, asynchronous
    input  wire logic       meas_in,
    // Sixteen-bit counter status
    output var  logic       counter16_running,
    output var  logic       counter16_zero
);

    // ============================================================
    // Register read decoding
    function automatic logic [7:0] read_reg
    (
        input logic [7:0]           addr,
        input tcr_pkg::tcr_regs_type r
    );
        logic [7:0] d;
        d = `TCR_RST_BYTE;
        if (addr == `TCR_OFS_CTRL)
        begin
            d[`TCR_CTRL_RUN_BIT]    = (r.state == tcr_pkg::TCR_RUN);
            d[`TCR_CTRL_MODULO_BIT] = r.modulo;
            d[`TCR_CTRL_DONE_BIT]   = r.done;
        end
        else if (addr == `TCR_OFS_RELOAD_LO)
            d = r.reload_lo;
        else if (addr == `TCR_OFS_RELOAD_HI)
            d = r.reload_hi;
        else if (addr == `TCR_OFS_CAP16_LO)
            d = r.cap16[7:0];
        else if (addr == `TCR_OFS_CAP16_HI)
            d = r.cap16[15:8];
        else if (addr == `TCR_OFS_CAP8_LO_PHASE)
            d = r.cap8_lo;
        else if (addr == `TCR_OFS_CAP8_HI_PHASE)
            d = r.cap8_hi;
        return d;
    endfunction : read_reg

    tcr_pkg::tcr_regs_type s;
    tcr_pkg::tcr_regs_type next_s;

    logic rise;
    logic fall;
    logic ctrl_wr;
    logic zero_evt;

    // ============================================================
    // Edge and event decode
    assign rise     = s.sync2 && !s.level_prev;
    assign fall     = !s.sync2 && s.level_prev;
    assign ctrl_wr  = reg_wr && (reg_addr == `TCR_OFS_CTRL);
    assign zero_evt = (s.state == tcr_pkg::TCR_RUN) && (s.cnt16 == `TCR_RST_WORD);

    // ============================================================
    // Next-state logic
    always_comb
    begin
        next_s            = s;
        next_s.sync1      = meas_in;
        next_s.sync2      = s.sync1;
        next_s.level_prev = s.sync2;
        next_s.zero_pulse = zero_evt;

        // Phase measurement: capture and restart on each input edge
        if (fall)
        begin
            next_s.cap8_hi = s.cnt8;
            next_s.cnt8    = `TCR_RST_BYTE;
        end
        else if (rise)
        begin
            next_s.cap8_lo = s.cnt8;
            next_s.cnt8    = `TCR_RST_BYTE;
        end
        else if (s.cnt8 != `TCR_CNT8_MAX)
            next_s.cnt8 = s.cnt8 + 8'h01;                     // Saturates

        // Whole 16-bit count caught on a rising input edge
        if (rise)
            next_s.cap16 = s.cnt16;

        // Sixteen-bit down counter
        case (s.state)
            tcr_pkg::TCR_RUN:
            begin
                if (zero_evt)
                begin
                    if (s.modulo)
                        next_s.cnt16 = {s.reload_hi, s.reload_lo};
                    else
                        next_s.state = tcr_pkg::TCR_IDLE;
                end
                else
                    next_s.cnt16 = s.cnt16 - 16'h0001;
            end
            default:
            begin
                next_s.state = tcr_pkg::TCR_IDLE;
            end
        endcase

        // Done flag: a zero event wins over a clear
        next_s.done = (s.done && !(ctrl_wr && reg_wdata[`TCR_CTRL_DONE_BIT])) || zero_evt;

        // Register writes; capture offsets take no write
        if (reg_wr)
        begin
            if (reg_addr == `TCR_OFS_RELOAD_HI)
                next_s.reload_hi = reg_wdata;
            else if (reg_addr == `TCR_OFS_RELOAD_LO)
                next_s.reload_lo = reg_wdata;
            else if (reg_addr == `TCR_OFS_CTRL)
            begin
                next_s.modulo = reg_wdata[`TCR_CTRL_MODULO_BIT];
                if (!reg_wdata[`TCR_CTRL_RUN_BIT])
                    next_s.state = tcr_pkg::TCR_IDLE;
                else if (s.state == tcr_pkg::TCR_IDLE)
                begin
                    next_s.state = tcr_pkg::TCR_RUN;
                    next_s.cnt16 = {s.reload_hi, s.reload_lo};
                end
            end
        end

        // Read data stands only in the cycle after the strobe
        if (reg_rd)
            next_s.rdata = read_reg(reg_addr, s);
        else
            next_s.rdata = `TCR_RST_BYTE;
    end

    // ============================================================
    // State register
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            s            <= '0;
            s.state      <= tcr_pkg::TCR_IDLE;
        end
        else
            s <= next_s;
    end

    // Outputs straight from flops
    assign reg_rdata         = s.rdata;
    assign counter16_running = (s.state == tcr_pkg::TCR_RUN);
    assign counter16_zero    = s.zero_pulse;

    // ============================================================
    // Assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence seq_mod_zero;
        zero_evt && s.modulo && !ctrl_wr;
    endsequence

    sequence seq_single_zero;
        zero_evt && !s.modulo && !ctrl_wr;
    endsequence

    sequence seq_mid_count;
        (s.state == tcr_pkg::TCR_RUN) && (s.cnt16 != `TCR_RST_WORD) && !ctrl_wr;
    endsequence

    a_cap8_high_phase: assert property (fall |=> s.cap8_hi == $past(s.cnt8))
        else $error("high phase capture wrong");
    a_cap8_low_phase: assert property (rise |=> s.cap8_lo == $past(s.cnt8))
        else $error("low phase capture wrong");
    a_cap16_high_byte: assert property (rise |=> s.cap16[15:8] == $past(s.cnt16[15:8]))
        else $error("16-bit high capture wrong");
    a_cap16_low_byte: assert property (rise |=> s.cap16[7:0] == $past(s.cnt16[7:0]))
        else $error("16-bit low capture wrong");
    a_cap16_read_back: assert property (reg_rd && reg_addr == `TCR_OFS_CAP16_HI
        |=> reg_rdata == $past(s.cap16[15:8]))
        else $error("16-bit capture read wrong");
    a_cap_write_ignored: assert property (reg_wr && reg_addr >= `TCR_OFS_CAP16_LO && !rise
        && !fall |=> $stable(s.cap16) && $stable(s.cap8_hi) && $stable(s.cap8_lo))
        else $error("capture changed by write");
    a_hold_write_read: assert property (reg_wr && reg_addr == `TCR_OFS_RELOAD_HI
        ##1 reg_rd && reg_addr == `TCR_OFS_RELOAD_HI && !reg_wr
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("hold byte readback wrong");
    a_modulo_reload: assert property (seq_mod_zero
        |=> s.cnt16 == {$past(s.reload_hi), $past(s.reload_lo)}
        && s.state == tcr_pkg::TCR_RUN)
        else $error("modulo reload wrong");
    a_single_stop: assert property (seq_single_zero |=> s.state == tcr_pkg::TCR_IDLE
        && !counter16_running)
        else $error("single pass did not stop");
    a_no_midcount_load: assert property (seq_mid_count
        |=> s.cnt16 == $past(s.cnt16) - 16'h0001)
        else $error("count disturbed mid count");
    a_zero_pulse: assert property (zero_evt |=> counter16_zero && s.done)
        else $error("zero event not flagged");

endmodule : tcr_top

`default_nettype wire

// [tcr_pulse_src.sv]
// Partner model: measured pulse source with programmable phase lengths
`timescale 1ns/1ps
`default_nettype none

module tcr_pulse_src
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    // Phase control
    input  wire logic       enable,
    input  wire logic [7:0] high_len,
    input  wire logic [7:0] low_len,
    // Pulse output
    output var  logic       meas_in
);
    // ============================================================
    // Phase timer
    logic [7:0] left;

    // Alternate high and low phases; finish the high phase and idle low
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            meas_in <= 1'b0;
            left    <= 8'h00;
        end
        else if (left != 8'h00)
            left <= left - 8'h01;
        else if (meas_in)
        begin
            meas_in <= 1'b0;
            left    <= low_len - 8'h01;
        end
        else if (enable)
        begin
            meas_in <= 1'b1;
            left    <= high_len - 8'h01;
        end
    end
endmodule : tcr_pulse_src
`default_nettype wire

// [timer_capture_hold_regs_bench.sv]
// Testbench of the capture and hold register block
`timescale 1ns/1ps
`default_nettype none

module timer_capture_hold_regs_bench;
    // ============================================================
    // Signals
    logic ref_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, pen = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, hl = 8'h01, ll = 8'h01;
    logic meas_in, counter16_running, counter16_zero;
    logic [7:0] d, h1, l1, l2;
    int failures = 0, compares = 0, since = 0, gap = 0;

    // Clock, 50 ns period
    always #25 ref_clk = ~ref_clk;

    tcr_top tcr_top_i (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .meas_in(meas_in), .counter16_running(counter16_running),
        .counter16_zero(counter16_zero));
    tcr_pulse_src tcr_pulse_src_i (.ref_clk(ref_clk), .resetn(resetn), .enable(pen),
        .high_len(hl), .low_len(ll), .meas_in(meas_in));

    // Cycles between zero pulses
    always @(posedge ref_clk)
    begin
        since <= counter16_zero ? 1 : since + 1;
        if (counter16_zero)
            gap <= since;
    end

    // ============================================================
    // Tasks
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd

    // Write then read back with no gap between the strobes
    task wr_rd(input logic [7:0] a, input logic [7:0] v, output logic [7:0] r);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 r = reg_rdata;
    endtask : wr_rd

    task wait_zero;
        int n;
        for (n = 0; n < 100 && counter16_zero !== 1'b1; n++)
        begin
            @(posedge ref_clk);
            #1;
        end
        check("zero pulse", {15'h0000, counter16_zero}, 16'h0001);
        @(posedge ref_clk);
        #1;
    endtask : wait_zero

    task pulses(input logic [7:0] h, input logic [7:0] l, output logic [7:0] ch,
                output logic [7:0] cl);
        @(posedge ref_clk);
        hl <= h;
        ll <= l;
        pen <= 1'b1;
        repeat (300) @(posedge ref_clk);
        pen <= 1'b0;
        repeat (60) @(posedge ref_clk);
        rd(8'h0B, ch);
        rd(8'h0A, cl);
    endtask : pulses

    task give_verdict;
        $display("Comparisons %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    // Watchdog
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        give_verdict();
    end

    // ============================================================
    // Main sequence
    initial
    begin
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        for (int a = 6; a < 12; a++)
        begin
            wr_rd(8'(a), 8'hC3, d);
            check("hold or capture", {8'h00, d}, (a < 8) ? 16'h00C3 : 16'h0000);
        end
        wr(8'h20, 8'h5A);
        rd(8'h20, d);
        check("unmapped", {8'h00, d}, 16'h0000);
        wr(8'h06, 8'h03);
        wr(8'h07, 8'h00);
        wr(8'h05, 8'h01);
        wait_zero();
        repeat (20) @(posedge ref_clk);
        check("single pass stop", {15'h0000, counter16_running}, 16'h0000);
        rd(8'h05, d);
        check("done flag", {8'h00, d}, 16'h0004);
        wr(8'h05, 8'h04);
        rd(8'h05, d);
        check("done cleared", {8'h00, d}, 16'h0000);
        wr(8'h06, 8'h05);
        wr(8'h05, 8'h03);
        wait_zero();
        wr(8'h06, 8'h02);
        wait_zero();
        check("old reload period", 16'(gap), 16'h0006);
        wait_zero();
        check("new reload period", 16'(gap), 16'h0003);
        wr(8'h05, 8'h00);
        wr(8'h07, 8'hA5);
        wr(8'h06, 8'h7F);
        wr(8'h05, 8'h01);
        wr(8'h05, 8'h00);
        pulses(8'd5, 8'd9, h1, l1);
        rd(8'h09, d);
        check("capture16 high", {8'h00, d}, 16'h00A5);
        rd(8'h08, d);
        check("capture16 low near", {15'h0000, d >= 8'h7B && d <= 8'h7F}, 16'h0001);
        pulses(8'd25, 8'd12, d, l2);
        check("high phase growth", {8'h00, d - h1}, 16'h0014);
        check("low phase growth", {8'h00, l2 - l1}, 16'h0003);
        rd(8'h0A, d);
        check("low capture reread", {8'h00, d - l1}, 16'h0003);
        // Second reset with the counter stopped: hold and capture bytes return to zero
        @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        rd(8'h07, d);
        check("hold byte after reset", {8'h00, d}, 16'h0000);
        rd(8'h09, d);
        check("capture16 after reset", {8'h00, d}, 16'h0000);
        give_verdict();
    end
endmodule : timer_capture_hold_regs_bench
`default_nettype wire
